/* logic/udh_defs.svh */
/*
  Offsets, field positions, reset values and timing counts of the UART
  data holding path. Assumes byte addresses on the plain register port.
*/
`ifndef UDH_DEFS_SVH
`define UDH_DEFS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define UDH_OFS_DATA 8'h00
`define UDH_OFS_DLH_IER 8'h04
`define UDH_OFS_FCR 8'h08
`define UDH_OFS_LCR 8'h0C
`define UDH_OFS_MCR 8'h10
`define UDH_OFS_LSR 8'h14
`define UDH_OFS_ISR 8'h40

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UDH_LCR_DIVISOR_LATCH_ACCESS_BIT 7
`define UDH_FCR_EN 0
`define UDH_FCR_RXCLR 1
`define UDH_FCR_TXCLR 2
`define UDH_MCR_SIR 6
`define UDH_LSR_DR 0
`define UDH_LSR_OE 1
`define UDH_LSR_TX_HOLDING_EMPTY 5
`define UDH_LSR_TEMT 6
`define UDH_INT_RX 0
`define UDH_INT_OVR 1
`define UDH_INT_TX_HOLDING_EMPTY 2
`define UDH_INT_W 3

// ----------------------------------------
// Reset values, sizes and timing
// ----------------------------------------
`define UDH_RST_BYTE 8'h00
`define UDH_RST_WORD 32'h0000_0000
`define UDH_FIFO_DEPTH 16
`define UDH_FIFO_AW 4
`define UDH_TICK_LAST 4'hF
`define UDH_TICK_HALF 4'h7
`define UDH_SIR_TICKS 4'h3
`define UDH_SIR_STRETCH 5'h10

`endif

/* logic/udh_pkg.sv */
/*
  Types of the UART data holding path.
  Assumes udh_defs.svh holds the numbers.
*/
package udh_pkg;

  // Gray coded along idle, start, data, stop
  typedef enum logic [1:0] {
    UDH_IDLE = 2'b00,
    UDH_START = 2'b01,
    UDH_DATA = 2'b11,
    UDH_STOP = 2'b10
  } udh_state_t;

  typedef struct packed {
    logic divisor_latch_access_bit;
    logic fifo_en;
    logic sir_mode;
  } udh_mode_t;

endpackage

/* logic/udh_fifo.sv */
/*
  Byte FIFO of fixed depth with valid/ready on both sides.
  Assumes one clock; clear empties it in one cycle.
*/
`timescale 1ns/1ns
`include "udh_defs.svh"

module udh_fifo
  import udh_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready
);

  logic [7:0] mem_reg [`UDH_FIFO_DEPTH];
  logic [7:0] mem_next [`UDH_FIFO_DEPTH];
  logic [`UDH_FIFO_AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [`UDH_FIFO_AW:0] count_reg, count_next;
  logic push, pop;

  assign in_ready = (count_reg != `UDH_FIFO_AW'(0) + (`UDH_FIFO_AW+1)'(`UDH_FIFO_DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (clear) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next = '0;
    end else begin
      if (push) begin
        mem_next[wr_ptr_reg] = in_data;
        wr_ptr_next = wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_next = rd_ptr_reg + 1'b1;
      end
      case ({push, pop})
        2'b10: count_next = count_reg + 1'b1;
        2'b01: count_next = count_reg - 1'b1;
        default: count_next = count_reg;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `UDH_FIFO_DEPTH; i++) begin
        mem_reg[i] <= `UDH_RST_BYTE;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

endmodule

/* logic/udh_tx_shift.sv */
/*
  Transmit serializer, 8 data bits, one start and one stop bit.
  Assumes tick16 pulses sixteen times per bit period.
*/
`timescale 1ns/1ns
`include "udh_defs.svh"

module udh_tx_shift
  import udh_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick16,
  input wire logic sir_mode,
  input wire logic load_valid,
  input wire logic [7:0] load_data,
  output logic load_ready,
  output logic busy,
  output logic sout,
  output logic sir_out_n
);

  udh_state_t state_reg, state_next;
  logic [3:0] tick_reg, tick_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic sout_reg, sout_next, sir_reg, sir_next;
  logic line_bit;

  assign load_ready = (state_reg == UDH_IDLE);
  assign busy = (state_reg != UDH_IDLE);
  assign sout = sout_reg;
  assign sir_out_n = sir_reg;

  always_comb begin
    state_next = state_reg;
    tick_next = tick_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    case (state_reg)
      UDH_IDLE: line_bit = 1'b1;
      UDH_START: line_bit = 1'b0;
      UDH_DATA: line_bit = shift_reg[0];
      default: line_bit = 1'b1;
    endcase
    if (state_reg == UDH_IDLE) begin
      if (load_valid) begin
        shift_next = load_data;
        tick_next = '0;
        state_next = UDH_START;
      end
    end else if (tick16) begin
      tick_next = tick_reg + 1'b1;
      if (tick_reg == `UDH_TICK_LAST) begin
        case (state_reg)
          UDH_START: begin
            bit_next = '0;
            state_next = UDH_DATA;
          end
          UDH_DATA: begin
            shift_next = {1'b0, shift_reg[7:1]};
            bit_next = bit_reg + 1'b1;
            if (bit_reg == 3'h7) begin
              state_next = UDH_STOP;
            end
          end
          default: state_next = UDH_IDLE;
        endcase
      end
    end
    // Infrared: short low pulse for each zero bit, line idles high
    sout_next = sir_mode ? 1'b1 : line_bit;
    sir_next = ~(sir_mode & ~line_bit & (tick_reg < `UDH_SIR_TICKS));
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= UDH_IDLE;
      tick_reg <= '0;
      bit_reg <= '0;
      shift_reg <= `UDH_RST_BYTE;
      sout_reg <= 1'b1;
      sir_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      tick_reg <= tick_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      sout_reg <= sout_next;
      sir_reg <= sir_next;
    end
  end

endmodule

/* logic/udh_top.sv */
/*
  UART data holding path: receive buffer and FIFO, transmit holding
  register and FIFO, baud divider, receiver, register port, interrupt.
  Assumes a host on the plain register port in the mclk domain and
  asynchronous serial and infrared pins; 8 data bits, no parity.
*/
`timescale 1ns/1ns
`include "udh_defs.svh"

// Operation
// - Receive data register shows received byte from serial or infrared input.
// - Without FIFOs, new byte overwrites unread byte and flags overrun.
// - With FIFOs, reading receive data returns oldest FIFO entry.
// - Full receive FIFO keeps entries, drops new byte, flags overrun.
// - Written transmit byte goes out on serial or active-low infrared output.
// - Without FIFOs, a transmit write clears the holding empty flag.
// - Without FIFOs, further writes before empty replace the pending byte.
// - With FIFOs, sixteen writes fill transmit FIFO behind a busy shifter, seventeen from idle.
// - Transmit write while FIFO is full is discarded.
// - Offset zero reaches divisor low byte only while divisor latch access set.
module udh_top
  import udh_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [31:0] rdata,
  input wire logic sin,
  input wire logic sir_in,
  output logic sout,
  output logic sir_out_n,
  output logic irq
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------
  // Control and status state
  // ----------------------------------------
  logic [7:0] dll_reg, dll_next, dlh_reg, dlh_next;
  logic [7:0] line_control_reg, line_control_next;
  logic [7:0] modem_ctrl_reg, modem_ctrl_next;
  logic [`UDH_INT_W-1:0] int_mask_reg, int_mask_next;
  logic [`UDH_INT_W-1:0] int_status_reg, int_status_next;
  logic fifo_en_reg, fifo_en_next;
  logic [7:0] rx_buffer_reg, rx_buffer_next;
  logic rx_hold_valid_reg, rx_hold_valid_next;
  logic [7:0] tx_holding_reg, tx_holding_next;
  logic tx_hold_valid_reg, tx_hold_valid_next;
  logic overrun_reg, overrun_next;
  logic tx_holding_empty_d_reg, tx_holding_empty_d_next;
  logic [31:0] rdata_reg, rdata_next;
  udh_mode_t mode;

  logic wr_data, rd_data, wr_fcr;
  logic rx_done, rx_overrun;
  logic [7:0] rx_byte;
  logic rx_data_available, tx_holding_empty, tx_empty;
  logic [7:0] line_status_reg;
  logic rxf_in_ready, rxf_out_valid, rxf_clear, rxf_pop;
  logic [7:0] rxf_out_data;
  logic txf_in_ready, txf_out_valid, txf_clear, txf_push;
  logic [7:0] txf_out_data;
  logic sh_load_valid, sh_load_ready, sh_busy;
  logic [7:0] sh_load_data;
  logic tick16;

  assign mode.divisor_latch_access_bit = line_control_reg[`UDH_LCR_DIVISOR_LATCH_ACCESS_BIT];
  assign mode.fifo_en = fifo_en_reg;
  assign mode.sir_mode = modem_ctrl_reg[`UDH_MCR_SIR];

  assign wr_data = wr_strobe & hit(addr, `UDH_OFS_DATA) & ~mode.divisor_latch_access_bit;
  assign rd_data = rd_strobe & hit(addr, `UDH_OFS_DATA) & ~mode.divisor_latch_access_bit;
  assign wr_fcr = wr_strobe & hit(addr, `UDH_OFS_FCR);

  // ----------------------------------------
  // Baud divider
  // ----------------------------------------
  // A divisor of zero stops the tick and so all serial traffic
  logic [15:0] baud_cnt_reg, baud_cnt_next;
  logic tick_reg, tick_next;

  always_comb begin
    baud_cnt_next = baud_cnt_reg + 16'h0001;
    tick_next = 1'b0;
    if ({dlh_reg, dll_reg} == 16'h0000) begin
      baud_cnt_next = 16'h0000;
    end else if (baud_cnt_reg >= {dlh_reg, dll_reg} - 16'h0001) begin
      baud_cnt_next = 16'h0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      baud_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      baud_cnt_reg <= baud_cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick16 = tick_reg;

  // ----------------------------------------
  // Pin synchronisers and infrared stretch
  // ----------------------------------------
  logic sin_s1_reg, sin_s2_reg, sir_s1_reg, sir_s2_reg;
  logic [4:0] stretch_reg, stretch_next;
  logic rx_line;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sin_s1_reg <= 1'b1;
      sin_s2_reg <= 1'b1;
      sir_s1_reg <= 1'b0;
      sir_s2_reg <= 1'b0;
    end else begin
      sin_s1_reg <= sin;
      sin_s2_reg <= sin_s1_reg;
      sir_s1_reg <= sir_in;
      sir_s2_reg <= sir_s1_reg;
    end
  end

  // Short infrared pulses are held for one bit time to look like a zero bit
  always_comb begin
    stretch_next = stretch_reg;
    if (sir_s2_reg) begin
      stretch_next = `UDH_SIR_STRETCH;
    end else if (tick16 && stretch_reg != 5'h00) begin
      stretch_next = stretch_reg - 5'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stretch_reg <= 5'h00;
    end else begin
      stretch_reg <= stretch_next;
    end
  end

  assign rx_line = mode.sir_mode ? (stretch_reg == 5'h00) : sin_s2_reg;

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  udh_state_t rx_state_reg, rx_state_next;
  logic [3:0] rx_tick_reg, rx_tick_next;
  logic [2:0] rx_bit_reg, rx_bit_next;
  logic [7:0] rx_shift_reg, rx_shift_next;
  logic rx_done_reg, rx_done_next;

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_tick_next = rx_tick_reg;
    rx_bit_next = rx_bit_reg;
    rx_shift_next = rx_shift_reg;
    rx_done_next = 1'b0;
    if (tick16) begin
      rx_tick_next = rx_tick_reg + 1'b1;
      case (rx_state_reg)
        UDH_IDLE: begin
          rx_tick_next = '0;
          if (!rx_line) begin
            rx_state_next = UDH_START;
          end
        end
        UDH_START: begin
          if (rx_tick_reg == `UDH_TICK_HALF) begin
            rx_tick_next = '0;
            rx_bit_next = '0;
            rx_state_next = rx_line ? UDH_IDLE : UDH_DATA;
          end
        end
        UDH_DATA: begin
          if (rx_tick_reg == `UDH_TICK_LAST) begin
            rx_shift_next = {rx_line, rx_shift_reg[7:1]};
            rx_bit_next = rx_bit_reg + 1'b1;
            if (rx_bit_reg == 3'h7) begin
              rx_state_next = UDH_STOP;
            end
          end
        end
        default: begin
          if (rx_tick_reg == `UDH_TICK_LAST) begin
            rx_done_next = 1'b1;
            rx_state_next = UDH_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_reg <= UDH_IDLE;
      rx_tick_reg <= '0;
      rx_bit_reg <= '0;
      rx_shift_reg <= `UDH_RST_BYTE;
      rx_done_reg <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_tick_reg <= rx_tick_next;
      rx_bit_reg <= rx_bit_next;
      rx_shift_reg <= rx_shift_next;
      rx_done_reg <= rx_done_next;
    end
  end

  assign rx_done = rx_done_reg;
  assign rx_byte = rx_shift_reg;

  // ----------------------------------------
  // FIFOs and transmitter
  // ----------------------------------------
  // Toggling the FIFO enable flushes both FIFOs so no stale bytes survive
  assign rxf_clear = wr_fcr & ((wdata[`UDH_FCR_EN] != fifo_en_reg) | wdata[`UDH_FCR_RXCLR]);
  assign txf_clear = wr_fcr & ((wdata[`UDH_FCR_EN] != fifo_en_reg) | wdata[`UDH_FCR_TXCLR]);
  assign rxf_pop = rd_data & fifo_en_reg;
  assign txf_push = wr_data & fifo_en_reg;

  udh_fifo rx_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .clear(rxf_clear),
    .in_valid(rx_done & fifo_en_reg),
    .in_data(rx_byte),
    .in_ready(rxf_in_ready),
    .out_valid(rxf_out_valid),
    .out_data(rxf_out_data),
    .out_ready(rxf_pop)
  );

  udh_fifo tx_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .clear(txf_clear),
    .in_valid(txf_push),
    .in_data(wdata[7:0]),
    .in_ready(txf_in_ready),
    .out_valid(txf_out_valid),
    .out_data(txf_out_data),
    .out_ready(fifo_en_reg & sh_load_ready)
  );

  assign sh_load_valid = fifo_en_reg ? txf_out_valid : tx_hold_valid_reg;
  assign sh_load_data = fifo_en_reg ? txf_out_data : tx_holding_reg;

  udh_tx_shift tx_shift (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick16(tick16),
    .sir_mode(mode.sir_mode),
    .load_valid(sh_load_valid),
    .load_data(sh_load_data),
    .load_ready(sh_load_ready),
    .busy(sh_busy),
    .sout(sout),
    .sir_out_n(sir_out_n)
  );

  // ----------------------------------------
  // Line status and register file
  // ----------------------------------------
  assign rx_data_available = fifo_en_reg ? rxf_out_valid : rx_hold_valid_reg;
  assign tx_holding_empty = fifo_en_reg ? ~txf_out_valid : ~tx_hold_valid_reg;
  assign tx_empty = tx_holding_empty & ~sh_busy;
  assign rx_overrun = rx_done & (fifo_en_reg ? ~rxf_in_ready : rx_hold_valid_reg);

  always_comb begin
    line_status_reg = 8'h00;
    line_status_reg[`UDH_LSR_DR] = rx_data_available;
    line_status_reg[`UDH_LSR_OE] = overrun_reg;
    line_status_reg[`UDH_LSR_TX_HOLDING_EMPTY] = tx_holding_empty;
    line_status_reg[`UDH_LSR_TEMT] = tx_empty;
  end

  always_comb begin
    dll_next = dll_reg;
    dlh_next = dlh_reg;
    line_control_next = line_control_reg;
    modem_ctrl_next = modem_ctrl_reg;
    int_mask_next = int_mask_reg;
    fifo_en_next = fifo_en_reg;
    rx_buffer_next = rx_buffer_reg;
    rx_hold_valid_next = rx_hold_valid_reg;
    tx_holding_next = tx_holding_reg;
    tx_hold_valid_next = tx_hold_valid_reg;
    tx_holding_empty_d_next = tx_holding_empty;
    rdata_next = `UDH_RST_WORD;
    if (wr_strobe) begin
      if (hit(addr, `UDH_OFS_DATA) && mode.divisor_latch_access_bit) dll_next = wdata[7:0];
      if (hit(addr, `UDH_OFS_DLH_IER) && mode.divisor_latch_access_bit) dlh_next = wdata[7:0];
      if (hit(addr, `UDH_OFS_DLH_IER) && !mode.divisor_latch_access_bit) int_mask_next = wdata[`UDH_INT_W-1:0];
      if (hit(addr, `UDH_OFS_LCR)) line_control_next = wdata[7:0];
      if (hit(addr, `UDH_OFS_MCR)) modem_ctrl_next = wdata[7:0];
      if (hit(addr, `UDH_OFS_FCR)) fifo_en_next = wdata[`UDH_FCR_EN];
    end
    // Pending byte taken by the shifter, a same-cycle write keeps the new one
    if (!fifo_en_reg && sh_load_ready && tx_hold_valid_reg) tx_hold_valid_next = 1'b0;
    if (wr_data && !fifo_en_reg) begin
      tx_holding_next = wdata[7:0];
      tx_hold_valid_next = 1'b1;
    end
    if (rd_data && !fifo_en_reg) rx_hold_valid_next = 1'b0;
    if (rx_done && !fifo_en_reg) begin
      rx_buffer_next = rx_byte;
      rx_hold_valid_next = 1'b1;
    end
    if (wr_fcr && wdata[`UDH_FCR_EN] != fifo_en_reg) begin
      rx_hold_valid_next = 1'b0;
      tx_hold_valid_next = 1'b0;
    end
    if (rd_strobe) begin
      case (addr)
        `UDH_OFS_DATA: begin
          if (mode.divisor_latch_access_bit) rdata_next = {24'h000000, dll_reg};
          else rdata_next = {24'h000000, fifo_en_reg ? rxf_out_data : rx_buffer_reg};
        end
        `UDH_OFS_DLH_IER: rdata_next = mode.divisor_latch_access_bit ? {24'h000000, dlh_reg} : {29'h0, int_mask_reg};
        `UDH_OFS_FCR: rdata_next = {31'h0, fifo_en_reg};
        `UDH_OFS_LCR: rdata_next = {24'h000000, line_control_reg};
        `UDH_OFS_MCR: rdata_next = {24'h000000, modem_ctrl_reg};
        `UDH_OFS_LSR: rdata_next = {24'h000000, line_status_reg};
        `UDH_OFS_ISR: rdata_next = {29'h0, int_status_reg};
        default: rdata_next = `UDH_RST_WORD;
      endcase
    end
  end

  // ----------------------------------------
  // Sticky flags: a set in the clear cycle wins
  // ----------------------------------------
  always_comb begin
    overrun_next = overrun_reg;
    if (rd_strobe && hit(addr, `UDH_OFS_LSR)) overrun_next = 1'b0;
    if (rx_overrun) overrun_next = 1'b1;
    int_status_next = int_status_reg;
    if (wr_strobe && hit(addr, `UDH_OFS_ISR)) int_status_next = int_status_reg & ~wdata[`UDH_INT_W-1:0];
    if (rx_done) int_status_next[`UDH_INT_RX] = 1'b1;
    if (rx_overrun) int_status_next[`UDH_INT_OVR] = 1'b1;
    if (tx_holding_empty && !tx_holding_empty_d_reg) int_status_next[`UDH_INT_TX_HOLDING_EMPTY] = 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dll_reg <= `UDH_RST_BYTE;
      dlh_reg <= `UDH_RST_BYTE;
      line_control_reg <= `UDH_RST_BYTE;
      modem_ctrl_reg <= `UDH_RST_BYTE;
      int_mask_reg <= '0;
      int_status_reg <= '0;
      fifo_en_reg <= 1'b0;
      rx_buffer_reg <= `UDH_RST_BYTE;
      rx_hold_valid_reg <= 1'b0;
      tx_holding_reg <= `UDH_RST_BYTE;
      tx_hold_valid_reg <= 1'b0;
      overrun_reg <= 1'b0;
      tx_holding_empty_d_reg <= 1'b1;
      rdata_reg <= `UDH_RST_WORD;
    end else begin
      dll_reg <= dll_next;
      dlh_reg <= dlh_next;
      line_control_reg <= line_control_next;
      modem_ctrl_reg <= modem_ctrl_next;
      int_mask_reg <= int_mask_next;
      int_status_reg <= int_status_next;
      fifo_en_reg <= fifo_en_next;
      rx_buffer_reg <= rx_buffer_next;
      rx_hold_valid_reg <= rx_hold_valid_next;
      tx_holding_reg <= tx_holding_next;
      tx_hold_valid_reg <= tx_hold_valid_next;
      overrun_reg <= overrun_next;
      tx_holding_empty_d_reg <= tx_holding_empty_d_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq = |(int_status_reg & int_mask_reg);

endmodule

/* test/udh_top_properties.sv */
/*
  Checker of the data holding path, bound to udh_top.
  Assumes it sees only the top ports; it keeps its own copy of the mode bits.
*/
`timescale 1ns/1ns
module udh_top_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [31:0] rdata,
  input wire logic sout,
  input wire logic sir_out_n,
  input wire logic irq
);
  // ----
  // Mode copy: sir, fifo, divisor_latch_access_bit, mask
  // ----
  logic [5:0] st_reg;
  logic [5:0] st_next;
  always_comb begin
    st_next = st_reg;
    if (wr_strobe && addr == 8'h0C) st_next[3] = wdata[7];
    if (wr_strobe && addr == 8'h08) st_next[4] = wdata[0];
    if (wr_strobe && addr == 8'h10) st_next[5] = wdata[6];
    if (wr_strobe && addr == 8'h04 && !st_reg[3]) st_next[2:0] = wdata[2:0];
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) st_reg <= 6'h00;
    else st_reg <= st_next;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_tx_wr;
    wr_strobe && addr == 8'h00 && st_reg[4:3] == 2'b00;
  endsequence
  sequence s_lsr_rd;
    rd_strobe && addr == 8'h14;
  endsequence
  sequence s_start_low;
    !sout [*8];
  endsequence
  AST_RDATA_IDLE: assert property (!$past(rd_strobe) |-> rdata == 32'h0)
    else $error("read data not zero outside read answer");
  AST_DATA_WIDTH: assert property (rd_strobe && addr == 8'h00 |=> rdata[31:8] == 24'h0)
    else $error("receive data upper bits not zero");
  AST_TX_HOLDING_EMPTY_CLEAR: assert property (s_tx_wr ##1 s_lsr_rd |=> !rdata[5])
    else $error("holding empty still set after write");
  AST_UNMAPPED: assert property (rd_strobe && addr == 8'h20 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_SIR_SOUT: assert property (st_reg[5] |-> sout)
    else $error("serial output moved in infrared mode");
  AST_NORMAL_SIR: assert property (!st_reg[5] |-> sir_out_n)
    else $error("infrared output moved in normal mode");
  AST_MASKED_IRQ: assert property (st_reg[2:0] == 3'h0 |-> !irq)
    else $error("interrupt raised while fully masked");
  AST_START_BIT: assert property ($fell(sout) |-> s_start_low)
    else $error("start bit too short");
endmodule
bind udh_top udh_top_properties i_props (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .sout(sout), .sir_out_n(sir_out_n), .irq(irq));

/* test/udh_line_model.sv */
/*
  Serial peripheral on the line side: sends frames, decodes sout.
  Assumes divisor 1, so one bit is 16 mclk cycles.
*/
`timescale 1ns/1ns
module udh_line_model (
  input wire logic mclk,
  input wire logic sout,
  output logic sin,
  output logic sir_in
);
  localparam int BIT = 16;
  logic [7:0] rx_q [$];
  logic [7:0] mon_b;
  initial begin
    sin = 1'b1;
    sir_in = 1'b0;
  end
  // Infrared zero bit is a 3 cycle high pulse
  task automatic send(input logic [7:0] b, input logic ir);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      if (ir) sir_in <= !f[i];
      else sin <= f[i];
      repeat (3) @(posedge mclk);
      sir_in <= 1'b0;
      repeat (BIT - 4) @(posedge mclk);
    end
  endtask
  // Stop bit value not checked, like the receiver
  initial forever begin
    @(negedge sout);
    repeat (BIT / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge mclk);
      mon_b[i] = sout;
    end
    repeat (BIT) @(posedge mclk);
    rx_q.push_back(mon_b);
  end
endmodule

/* test/udh_top_bench.sv */
/*
  Self-checking bench of udh_top with a line model.
  Assumes divisor 1 so frames take 160 cycles.
*/
`timescale 1ns/1ns
module udh_top_bench;
  import udh_pkg::*;
  typedef struct packed { logic [7:0] a; logic [31:0] e; } udh_row_t;
  logic mclk, rst_n, wr_strobe, rd_strobe, sin, sir_in, sout, sir_out_n, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  int n_fail, checks_done, cyc, lows;
  udh_row_t rows [8] = '{'{8'h00, 32'h0}, '{8'h04, 32'h0}, '{8'h08, 32'h0}, '{8'h0C, 32'h0},
    '{8'h10, 32'h0}, '{8'h14, 32'h60}, '{8'h40, 32'h0}, '{8'h20, 32'h0}};
  udh_top i_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rdata(rdata), .sin(sin), .sir_in(sir_in), .sout(sout),
    .sir_out_n(sir_out_n), .irq(irq));
  udh_line_model i_line (.mclk(mclk), .sout(sout), .sin(sin), .sir_in(sir_in));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Ceiling well above the roughly 7450 cycles the tests need
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    rd_strobe <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic idle;
    wr_strobe <= 1'b0;
    rd_strobe <= 1'b0;
    @(posedge mclk);
  endtask
  // Answer stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
    addr <= a;
    rd_strobe <= 1'b1;
    wr_strobe <= 1'b0;
    @(posedge mclk);
    rd_strobe <= 1'b0;
    @(negedge mclk) chk(n, e, rdata & m);
    @(posedge mclk);
  endtask
  initial begin
    {wr_strobe, rd_strobe, addr, wdata, rst_n} = '0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    foreach (rows[i]) rd(rows[i].a, 32'hFFFFFFFF, rows[i].e, "reset value");
    $display("test reset done");
    wr(8'h0C, 32'h80);
    wr(8'h00, 32'h01);
    rd(8'h00, 32'hFF, 32'h01, "divisor low");
    wr(8'h04, 32'h00);
    wr(8'h0C, 32'h00);
    idle();
    i_line.send(8'hA5, 1'b0);
    repeat (20) @(posedge mclk);
    rd(8'h14, 32'h1, 32'h1, "data ready");
    rd(8'h00, 32'hFF, 32'hA5, "rx byte");
    i_line.send(8'h3C, 1'b0);
    i_line.send(8'hC3, 1'b0);
    repeat (20) @(posedge mclk);
    rd(8'h14, 32'h3, 32'h3, "overrun");
    rd(8'h00, 32'hFF, 32'hC3, "overwrite");
    rd(8'h40, 32'h3, 32'h3, "int status");
    wr(8'h04, 32'h3);
    idle();
    @(negedge mclk) chk("irq on", 32'h1, {31'h0, irq});
    @(posedge mclk);
    wr(8'h40, 32'h7);
    idle();
    @(negedge mclk) chk("irq cleared", 32'h0, {31'h0, irq});
    @(posedge mclk);
    wr(8'h04, 32'h0);
    $display("test rx plain done");
    wr(8'h00, 32'h11);
    rd(8'h14, 32'h20, 32'h0, "holding empty");
    repeat (4) @(posedge mclk);
    wr(8'h00, 32'h22);
    wr(8'h00, 32'h33);
    idle();
    repeat (400) @(posedge mclk);
    chk("tx count", 32'd2, i_line.rx_q.size());
    chk("tx first", 32'h11, {24'h0, i_line.rx_q[0]});
    chk("tx replaced", 32'h33, {24'h0, i_line.rx_q[1]});
    $display("test tx plain done");
    wr(8'h10, 32'h40);
    wr(8'h00, 32'h00);
    idle();
    lows = 0;
    for (int k = 0; k < 200; k++) begin
      @(negedge mclk);
      if (sir_out_n === 1'b0) lows++;
    end
    chk("ir pulse cycles", 32'd27, lows);
    i_line.send(8'h5A, 1'b1);
    repeat (20) @(posedge mclk);
    rd(8'h00, 32'hFF, 32'h5A, "ir rx byte");
    wr(8'h10, 32'h00);
    $display("test infrared done");
    wr(8'h08, 32'h1);
    idle();
    for (int i = 1; i <= 17; i++) i_line.send(8'(8'h10 + i), 1'b0);
    repeat (20) @(posedge mclk);
    rd(8'h14, 32'h3, 32'h3, "fifo overrun");
    for (int i = 1; i <= 16; i++) rd(8'h00, 32'hFF, 32'h10 + i, "fifo head");
    rd(8'h14, 32'h1, 32'h0, "fifo drained");
    $display("test rx fifo done");
    i_line.rx_q.delete();
    for (int i = 1; i <= 20; i++) wr(8'h00, 32'h40 + i);
    rd(8'h14, 32'h20, 32'h0, "fifo not empty");
    repeat (3100) @(posedge mclk);
    chk("fifo tx count", 32'd17, i_line.rx_q.size());
    chk("fifo tx last", 32'h51, {24'h0, i_line.rx_q[16]});
    $display("test tx fifo done");
    i_line.send(8'h77, 1'b0);
    repeat (20) @(posedge mclk);
    rd(8'h14, 32'h1, 32'h1, "rx fifo filled");
    wr(8'h08, 32'h3);
    idle();
    rd(8'h14, 32'h1, 32'h0, "rx fifo cleared");
    $display("test fifo clear done");
    test_done();
  end
endmodule
